//--- hw/etr_flags.sv
// Sticky event flags, cleared by a clear pulse except those set again in the same cycle.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module etr_flags #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic clear_all,
    output logic [WIDTH-1:0] flags
);
    typedef struct packed {
        logic [WIDTH-1:0] flag;
    } etr_flags_state_t;

    etr_flags_state_t state_reg;
    etr_flags_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        // Set wins over a clear in the same cycle
        for (int i = 0; i < WIDTH; i++)
        begin
            state_next.flag[i] = set_in[i] | (state_reg.flag[i] & ~clear_all);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flag;
endmodule // etr_flags
`default_nettype wire

//--- hw/etr_pkg.sv
// Register map, field layout and reset values of the boost table and event block.
// Assumes an 8-bit register address space on the management port.
`default_nettype none
package etr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_ENTRIES = 4;
    localparam int unsigned NUM_STAGES = 4;
    localparam int unsigned STAGE_W = 2;
    localparam int unsigned NUM_FLAGS = 8;

    // Offsets
    localparam logic [7:0] OFS_ENTRY_12 = 8'h4C;
    localparam logic [7:0] OFS_ENTRY_13 = 8'h4D;
    localparam logic [7:0] OFS_ENTRY_14 = 8'h4E;
    localparam logic [7:0] OFS_ENTRY_15 = 8'h4F;
    localparam logic [7:0] OFS_RSVD_A = 8'h50;
    localparam logic [7:0] OFS_RSVD_B = 8'h51;
    localparam logic [7:0] OFS_READBACK = 8'h52;
    localparam logic [7:0] OFS_RSVD_C = 8'h53;
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h54;
    localparam logic [7:0] OFS_RSVD_D = 8'h55;
    localparam logic [7:0] OFS_EVENT_ENABLES = 8'h56;

    // Reset values
    localparam logic [7:0] RST_ENTRY_12 = 8'h99;
    localparam logic [7:0] RST_ENTRY_13 = 8'hA5;
    localparam logic [7:0] RST_ENTRY_14 = 8'hE6;
    localparam logic [7:0] RST_ENTRY_15 = 8'hF9;
    localparam logic [7:0] RST_RSVD = 8'h00;
    localparam logic [7:0] RST_RSVD_D = 8'h02;
    localparam logic [7:0] RST_READBACK = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;

    // Stage field low bit positions inside an entry
    localparam int unsigned STAGE0_LSB = 6;
    localparam int unsigned STAGE1_LSB = 4;
    localparam int unsigned STAGE2_LSB = 2;
    localparam int unsigned STAGE3_LSB = 0;

    // Event flag and enable bit positions
    localparam int unsigned BIT_SEL_CARRIER = 7;
    localparam int unsigned BIT_LOCK_FOUND = 6;
    localparam int unsigned BIT_IN1_FOUND = 5;
    localparam int unsigned BIT_IN0_FOUND = 4;
    localparam int unsigned BIT_EYE_REACHED = 3;
    localparam int unsigned BIT_LOCK_LOST = 2;
    localparam int unsigned BIT_IN1_LOST = 1;
    localparam int unsigned BIT_IN0_LOST = 0;
    localparam logic [7:0] ENABLES_MASK = 8'h7F;
endpackage : etr_pkg
`default_nettype wire

//--- hw/etr_regs.sv
// Boost table entries 12..15, adapted boost readback and event flag registers.
// Assumes a host command port on core_clk and pin-level status inputs.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Entry packs four 2-bit stage controls
// - Entries 12,13 writable, reset 0x99, 0xA5
// - Entries 14,15 writable, reset 0xE6, 0xF9
// - Read-only adapted boost readback, resets zero
// - Reading status register clears every flag not set again in the read cycle
// - Bit 7 set while selected input carrier present
// - Bit 6 set on lock achieved
// - Bits 5,4 set on carrier found
// - Bit 3 set on eye threshold reached
// - Bit 2 set on lock loss
// - Bits 1,0 set on carrier loss
// - Enable bit 6 gates lock achieved
// - Enable bit 5 gates input1 found
// - Enable bits 4..0 gate remaining events
module etr_regs (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic cdr_locked,
    input wire logic first_input_carrier,
    input wire logic second_input_carrier,
    input wire logic second_input_selected,
    input wire logic eye_threshold_reached,
    input wire logic [7:0] adapted_boost_value,
    output logic [7:0] boost_entry_12,
    output logic [7:0] boost_entry_13,
    output logic [7:0] boost_entry_14,
    output logic [7:0] boost_entry_15
);
    localparam int unsigned PIN_W = 5;

    typedef struct packed {
        logic [etr_pkg::NUM_ENTRIES-1:0][7:0] entry;
        logic [7:0] enables;
        logic [7:0] readback;
        logic [3:0] prev_level;
        logic [7:0] rd_data;
        logic rd_valid;
    } etr_regs_state_t;

    etr_regs_state_t state_reg;
    etr_regs_state_t state_next;

    logic [PIN_W-1:0] pins_sync;
    logic [7:0] boost_sync;
    logic [7:0] flag_set;
    logic [7:0] flags;
    logic flag_clear;
    logic lock_s;
    logic c0_s;
    logic c1_s;
    logic sel_s;
    logic eye_s;
    logic [3:0] level_now;
    logic [7:0] event_raw;
    logic [7:0] wr_stage_data [etr_pkg::NUM_ENTRIES];
    logic [etr_pkg::NUM_ENTRIES-1:0] entry_hit;

    etr_sync #(
        .WIDTH(PIN_W)
    ) u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({cdr_locked, first_input_carrier, second_input_carrier,
            second_input_selected, eye_threshold_reached}),
        .sync_out(pins_sync)
    );

    etr_sync #(
        .WIDTH(8)
    ) u_boost_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(adapted_boost_value),
        .sync_out(boost_sync)
    );

    assign lock_s = pins_sync[4];
    assign c0_s = pins_sync[3];
    assign c1_s = pins_sync[2];
    assign sel_s = pins_sync[1];
    assign eye_s = pins_sync[0];
    assign level_now = {lock_s, c1_s, c0_s, eye_s};

    // Edge events from synchronised levels; bit 7 is the selected carrier level
    always_comb
    begin
        event_raw = '0;
        event_raw[etr_pkg::BIT_SEL_CARRIER] = sel_s ? c1_s : c0_s;
        event_raw[etr_pkg::BIT_LOCK_FOUND] = lock_s & ~state_reg.prev_level[3];
        event_raw[etr_pkg::BIT_IN1_FOUND] = c1_s & ~state_reg.prev_level[2];
        event_raw[etr_pkg::BIT_IN0_FOUND] = c0_s & ~state_reg.prev_level[1];
        event_raw[etr_pkg::BIT_EYE_REACHED] = eye_s & ~state_reg.prev_level[0];
        event_raw[etr_pkg::BIT_LOCK_LOST] = ~lock_s & state_reg.prev_level[3];
        event_raw[etr_pkg::BIT_IN1_LOST] = ~c1_s & state_reg.prev_level[2];
        event_raw[etr_pkg::BIT_IN0_LOST] = ~c0_s & state_reg.prev_level[1];
    end

    // Enable gating; bit 7 has no enable
    always_comb
    begin
        flag_set = event_raw & state_reg.enables;
        flag_set[etr_pkg::BIT_SEL_CARRIER] = event_raw[etr_pkg::BIT_SEL_CARRIER];
    end

    assign flag_clear = reg_rd_en && (reg_addr == etr_pkg::OFS_EVENT_FLAGS);

    etr_flags #(
        .WIDTH(etr_pkg::NUM_FLAGS)
    ) u_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_in(flag_set),
        .clear_all(flag_clear),
        .flags(flags)
    );

    // Per-entry decode and stage-by-stage field write
    genvar g;
    generate
        for (g = 0; g < etr_pkg::NUM_ENTRIES; g++)
        begin : g_entry
            assign entry_hit[g] = reg_addr == (etr_pkg::OFS_ENTRY_12 + 8'(g));
            always_comb
            begin
                wr_stage_data[g] = '0;
                wr_stage_data[g][etr_pkg::STAGE0_LSB +: 2] =
                    reg_wr_data[etr_pkg::STAGE0_LSB +: 2];
                wr_stage_data[g][etr_pkg::STAGE1_LSB +: 2] =
                    reg_wr_data[etr_pkg::STAGE1_LSB +: 2];
                wr_stage_data[g][etr_pkg::STAGE2_LSB +: 2] =
                    reg_wr_data[etr_pkg::STAGE2_LSB +: 2];
                wr_stage_data[g][etr_pkg::STAGE3_LSB +: 2] =
                    reg_wr_data[etr_pkg::STAGE3_LSB +: 2];
            end
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        state_next.prev_level = level_now;
        state_next.readback = boost_sync;
        for (int i = 0; i < etr_pkg::NUM_ENTRIES; i++)
        begin
            if (reg_wr_en && entry_hit[i])
            begin
                state_next.entry[i] = wr_stage_data[i];
            end
        end
        if (reg_wr_en && reg_addr == etr_pkg::OFS_EVENT_ENABLES)
        begin
            state_next.enables = reg_wr_data & etr_pkg::ENABLES_MASK;
        end
        state_next.rd_valid = reg_rd_en;
        if (reg_rd_en)
        begin
            case (reg_addr)
                etr_pkg::OFS_ENTRY_12: state_next.rd_data = state_reg.entry[0];
                etr_pkg::OFS_ENTRY_13: state_next.rd_data = state_reg.entry[1];
                etr_pkg::OFS_ENTRY_14: state_next.rd_data = state_reg.entry[2];
                etr_pkg::OFS_ENTRY_15: state_next.rd_data = state_reg.entry[3];
                etr_pkg::OFS_READBACK: state_next.rd_data = state_reg.readback;
                etr_pkg::OFS_EVENT_FLAGS: state_next.rd_data = flags;
                etr_pkg::OFS_RSVD_D: state_next.rd_data = etr_pkg::RST_RSVD_D;
                etr_pkg::OFS_EVENT_ENABLES: state_next.rd_data = state_reg.enables;
                default: state_next.rd_data = etr_pkg::RST_RSVD;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg.entry[0] <= etr_pkg::RST_ENTRY_12;
            state_reg.entry[1] <= etr_pkg::RST_ENTRY_13;
            state_reg.entry[2] <= etr_pkg::RST_ENTRY_14;
            state_reg.entry[3] <= etr_pkg::RST_ENTRY_15;
            state_reg.enables <= etr_pkg::RST_ENABLES;
            state_reg.readback <= etr_pkg::RST_READBACK;
            state_reg.prev_level <= '0;
            state_reg.rd_data <= '0;
            state_reg.rd_valid <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rd_data = state_reg.rd_data;
    assign reg_rd_valid = state_reg.rd_valid;
    assign boost_entry_12 = state_reg.entry[0];
    assign boost_entry_13 = state_reg.entry[1];
    assign boost_entry_14 = state_reg.entry[2];
    assign boost_entry_15 = state_reg.entry[3];

    // Checks
    sequence s_flag_read;
        reg_rd_en && reg_addr == etr_pkg::OFS_EVENT_FLAGS;
    endsequence

    sequence s_quiet_after;
        flag_set == 8'h00;
    endsequence

    a_reset_entries: assert property (@(posedge core_clk)
        $past(sys_rst) |-> boost_entry_12 == 8'h99 && boost_entry_13 == 8'hA5)
        else $error("entry 12/13 reset value wrong");

    a_reset_entries_hi: assert property (@(posedge core_clk)
        $past(sys_rst) |-> boost_entry_14 == 8'hE6 && boost_entry_15 == 8'hF9)
        else $error("entry 14/15 reset value wrong");

    a_entry_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr_en && reg_addr == 8'h4D |=> boost_entry_13 == $past(reg_wr_data))
        else $error("entry write not stored");

    a_entry12_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr_en && reg_addr == 8'h4C |=> boost_entry_12 == $past(reg_wr_data))
        else $error("entry 12 write not stored");

    a_entry15_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr_en && reg_addr == 8'h4F |=> boost_entry_15 == $past(reg_wr_data))
        else $error("entry 15 write not stored");

    a_read_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_flag_read ##0 s_quiet_after |=> flags == 8'h00)
        else $error("flags not cleared by read");

    a_read_returns: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_flag_read |=> reg_rd_valid && reg_rd_data == $past(flags))
        else $error("status read data wrong");

    a_gate_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
        !state_reg.enables[6] && !flags[6] |=> !flags[6])
        else $error("disabled lock event latched");

    a_gate_all: assert property (@(posedge core_clk) disable iff (sys_rst)
        (flags[6:0] & ~state_reg.enables[6:0]) == 7'h00
            |=> (flags[6:0] & ~$past(state_reg.enables[6:0])) == 7'h00)
        else $error("disabled event latched");

    a_lock_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[6] && lock_s && !state_reg.prev_level[3] |=> flags[6])
        else $error("lock event not latched");

    a_lost_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[2] && !lock_s && state_reg.prev_level[3] |=> flags[2])
        else $error("lock loss not latched");

    a_in1_found_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[5] && c1_s && !state_reg.prev_level[2] |=> flags[5])
        else $error("input1 found event not latched");

    a_in0_found_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[4] && c0_s && !state_reg.prev_level[1] |=> flags[4])
        else $error("input0 found event not latched");

    a_eye_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[3] && eye_s && !state_reg.prev_level[0] |=> flags[3])
        else $error("eye threshold event not latched");

    a_in1_lost_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[1] && !c1_s && state_reg.prev_level[2] |=> flags[1])
        else $error("input1 loss event not latched");

    a_in0_lost_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[0] && !c0_s && state_reg.prev_level[1] |=> flags[0])
        else $error("input0 loss event not latched");

    a_carrier_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sel_s ? c1_s : c0_s) |=> flags[7])
        else $error("selected carrier bit not set");

    a_carrier_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(sel_s ? c1_s : c0_s) && flag_clear |=> !flags[7])
        else $error("selected carrier bit not cleared");

    a_sticky_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        flags[1] && !flag_clear |=> flags[1])
        else $error("flag dropped without read");

    a_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rd_en && reg_addr == 8'h52 |=> reg_rd_data == $past(state_reg.readback))
        else $error("readback data wrong");

    a_readback_ro: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.readback == $past(boost_sync))
        else $error("readback not following adapted value");

    a_enable_rsvd: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg.enables[7] == 1'b0)
        else $error("reserved enable bit set");

endmodule // etr_regs
`default_nettype wire

//--- hw/etr_sync.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes multi-bit inputs change slowly relative to the clock.
`timescale 1ns/10ps
`default_nettype none
module etr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } etr_sync_state_t;

    etr_sync_state_t state_reg;
    etr_sync_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule // etr_sync
`default_nettype wire

//--- verif/etr_host_model.sv
// Host controller model driving the register command port.
// Assumes the register port contract: strobes sampled on rising core_clk.
`timescale 1ns/10ps
`default_nettype none
module etr_host_model (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // Single write, released lines show inverted value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask

    // One register read per call, every bit taken from it
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int i;
        ok = 1'b0;
        d = 8'h00;
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        for (i = 0; i < 4 && !ok; i++)
        begin
            #1;
            if (reg_rd_valid === 1'b1)
            begin
                d = reg_rd_data;
                ok = 1'b1;
            end
            else
                @(posedge core_clk);
        end
    endtask
endmodule // etr_host_model
`default_nettype wire

//--- verif/etr_regs_bench.sv
// Self-checking bench for the boost table and event flag registers.
// Assumes etr_pkg, etr_regs and etr_host_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module etr_regs_bench;
    logic core_clk;
    logic sys_rst;
    logic cdr_locked;
    logic first_input_carrier;
    logic second_input_carrier;
    logic second_input_selected;
    logic eye_threshold_reached;
    logic [7:0] adapted_boost_value;
    logic [7:0] reg_addr;
    logic reg_wr_en;
    logic [7:0] reg_wr_data;
    logic reg_rd_en;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid;
    logic [7:0] boost_entry [4];
    int fail_count;
    int checked;
    int ev_bit [7] = '{6, 2, 4, 0, 5, 1, 3};
    int ev_sig [7] = '{0, 0, 1, 1, 2, 2, 3};
    logic ev_lvl [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    etr_host_model etr_host_model_i (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));

    etr_regs etr_regs_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .cdr_locked(cdr_locked),
        .first_input_carrier(first_input_carrier), .second_input_carrier(second_input_carrier),
        .second_input_selected(second_input_selected),
        .eye_threshold_reached(eye_threshold_reached),
        .adapted_boost_value(adapted_boost_value), .boost_entry_12(boost_entry[0]),
        .boost_entry_13(boost_entry[1]), .boost_entry_14(boost_entry[2]),
        .boost_entry_15(boost_entry[3]));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [7:0] rst_exp(input logic [7:0] a);
        case (a)
            8'h4C: return 8'h99;
            8'h4D: return 8'hA5;
            8'h4E: return 8'hE6;
            8'h4F: return 8'hF9;
            8'h55: return 8'h02;
            default: return 8'h00;
        endcase
    endfunction

    // Stage 0 in the top pair down to stage 3 in the bottom pair
    function automatic logic [7:0] pack_entry(input logic [1:0] s0, input logic [1:0] s1,
        input logic [1:0] s2, input logic [1:0] s3);
        return {s0, s1, s2, s3};
    endfunction

    function automatic logic [7:0] sel_carrier();
        return {(second_input_selected ? second_input_carrier : first_input_carrier), 7'h00};
    endfunction

    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdm(input string name, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        etr_host_model_i.rd(a, d, ok);
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("[FAIL] %s read answer expected 1 seen 0", name);
            summarize();
        end
        else
            check(name, exp & m, d & m);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
        rdm(name, a, 8'hFF, exp);
    endtask

    task automatic set_sig(input int idx, input logic v);
        @(posedge core_clk);
        case (idx)
            0: cdr_locked <= v;
            1: first_input_carrier <= v;
            2: second_input_carrier <= v;
            default: eye_threshold_reached <= v;
        endcase
        repeat (6) @(posedge core_clk);
    endtask

    initial
    begin
        logic [7:0] v;
        logic [7:0] en;
        logic [7:0] a;
        logic [7:0] pre;
        fail_count = 0;
        checked = 0;
        sys_rst = 1'b1;
        cdr_locked = 1'b0;
        first_input_carrier = 1'b0;
        second_input_carrier = 1'b0;
        second_input_selected = 1'b0;
        eye_threshold_reached = 1'b0;
        adapted_boost_value = 8'h00;
        void'($urandom(64145));
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 12; k++)
        begin
            a = (k == 11) ? 8'h80 : 8'h4C + 8'(k);
            rdc("reset value", a, rst_exp(a));
        end
        $display("test reset values done");
        for (int k = 0; k < 12; k++)
        begin
            v = pack_entry(2'($urandom), 2'($urandom), 2'($urandom), 2'($urandom));
            etr_host_model_i.wr(8'h4C + 8'(k % 4), v);
            #1;
            check("entry port", v, boost_entry[k % 4]);
            rdc("entry read", 8'h4C + 8'(k % 4), v);
        end
        etr_host_model_i.wr(8'h50, 8'hFF);
        rdc("reserved write", 8'h50, 8'h00);
        etr_host_model_i.wr(8'h52, 8'hFF);
        rdc("readback write", 8'h52, 8'h00);
        $display("test table writes done");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            a = 8'h4C + 8'(k);
            rdc("entry after reset", a, rst_exp(a));
        end
        $display("test mid-run reset done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge core_clk);
            adapted_boost_value <= 8'($urandom);
            repeat (6) @(posedge core_clk);
            rdc("adapted readback", 8'h52, adapted_boost_value);
        end
        $display("test readback done");
        etr_host_model_i.wr(8'h56, 8'hFF);
        rdc("enables", 8'h56, 8'h7F);
        for (int k = 0; k < 7; k++)
        begin
            for (int j = 0; j < 2; j++)
            begin
                en = (j == 0) ? 8'h00 : (8'h01 << ev_bit[k]);
                etr_host_model_i.wr(8'h56, 8'h00);
                @(posedge core_clk);
                second_input_selected <= 1'($urandom);
                set_sig(ev_sig[k], !ev_lvl[k]);
                etr_host_model_i.wr(8'h56, en);
                rdm("flags before event", 8'h54, 8'h7F, 8'h00);
                pre = sel_carrier();
                set_sig(ev_sig[k], ev_lvl[k]);
                rdc("event flags", 8'h54, en | pre | sel_carrier());
                rdc("flags after read", 8'h54, sel_carrier());
            end
        end
        $display("test event flags done");
        summarize();
    end
endmodule // etr_regs_bench
`default_nettype wire
